/* File: src/ipm_power_ctrl.sv */
`timescale 1ns/10ps
`include "ipm_map.svh"

// Operation
// RULE1 - boot of at most 10 ms loads trim values before normal operation
// RULE2 - after boot both sensors sit in power-down without host action
// RULE3 - accel only, gyro only, or both active at independent rates
// RULE4 - each sensor independently power-down, low-power or high-performance
// RULE5 - with both active, accel sampling is locked to gyro ticks; code aligns only accel start from power-down to a gyro period end
// RULE6 - accel mode and rate come from rate code plus hp-disable bit
// RULE7 - accel code 0000 means power-down regardless of disable bit
// RULE8 - accel codes 0001 to 0101: disable bit 1 low-power, 0 high-performance
// RULE9 - accel code 1011: 1.6 Hz low-power or 12.5 Hz high-performance
// RULE10 - codes 0110 to 1010 are high-performance for both sensors
// RULE11 - gyro code/disable bit decode like accel; 0000 power-down
// RULE12 - gyro not power-down and sleep request set means gyro sleeps
// RULE13 - sleep request ignored while gyro code is power-down
// RULE14 - host serial interface stays live during power-down
// RULE15 - power-down keeps config and freezes output data at last sample
// RULE16 - high-performance keeps chain on, samples at rate, flags data ready
// RULE17 - low-power gates reading chain between samples, still flags data ready
// RULE18 - host-only connection mode is the default
// RULE19 - second mode adds a two-wire master, host interface kept
// RULE20 - accel anti-aliasing stage on only in high-performance mode
// RULE21 - fixed lowpass cutoff: half rate in high-performance, 700 Hz low-power
// RULE22 - mode or rate change applies only when current period ends
// RULE23 - unassigned rate codes act as power-down

module ipm_power_ctrl #(
    parameter int BOOT_CYC = `IPM_BOOT_CYC, // boot length in clocks
    parameter int TRIM_WORDS = 8, // trim words loaded at boot
    parameter int BASE_DIV = 3 // clocks per base tick of 6667 Hz scale
) (
    input wire logic clock, // 20 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [3:0] accel_rate_code, // accel rate code
    input wire logic accel_hp_disable, // accel hp disable bit
    input wire logic [3:0] gyro_rate_code, // gyro rate code
    input wire logic gyro_hp_disable, // gyro hp disable bit
    input wire logic gyro_sleep_req, // gyro sleep request
    input wire logic hub_mode_req, // sensor hub connection mode request
    input wire logic host_if_req, // host serial activity, async pin
    output logic boot_done, // boot complete
    output logic [1:0] accel_mode, // accel power mode
    output logic [1:0] gyro_mode, // gyro power mode
    output logic accel_drdy, // accel data ready pulse
    output logic gyro_drdy, // gyro data ready pulse
    output logic accel_chain_on, // accel reading chain powered
    output logic gyro_chain_on, // gyro reading chain powered
    output logic gyro_drive_on, // gyro mass drive powered
    output logic accel_aa_en, // accel anti-aliasing enable
    output logic [15:0] first_digital_lowpass, // accel lowpass cutoff in Hz
    output logic host_if_en, // host serial slave enabled
    output logic hub_master_en, // two-wire master enabled
    output logic data_update_en, // output data registers may update
    output logic host_if_seen // host activity seen, synchronised
);

    // rate decode: mode and period in base ticks (6667 Hz = 1 tick)
    function automatic logic [17:0] decode(input logic [3:0] code, input logic hpd,
                                           input logic is_accel);
        ipm_pkg::ipm_mode_t m;
        logic [15:0] per;
        m = ipm_pkg::IPM_PD; // RULE7 RULE23
        per = 16'h0000;
        case (code)
            4'h1: per = 16'h0215;
            4'h2: per = 16'h0100;
            4'h3: per = 16'h0080;
            4'h4: per = 16'h0040;
            4'h5: per = 16'h0020;
            4'h6: per = 16'h0010;
            4'h7: per = 16'h0008;
            4'h8: per = 16'h0004;
            4'h9: per = 16'h0002;
            4'hA: per = 16'h0001;
            4'hB: per = (is_accel && hpd) ? 16'h1000 : 16'h0215;
            default: per = 16'h0000;
        endcase
        if (code >= `IPM_CODE_LP_LO && code <= `IPM_CODE_LP_HI)
        begin
            m = hpd ? ipm_pkg::IPM_LP : ipm_pkg::IPM_HP; // RULE8 RULE11
        end
        else if (code >= `IPM_CODE_HP_LO && code <= `IPM_CODE_HP_HI)
        begin
            m = ipm_pkg::IPM_HP; // RULE10
        end
        else if (is_accel && code == `IPM_CODE_XL_1P6)
        begin
            m = hpd ? ipm_pkg::IPM_LP : ipm_pkg::IPM_HP; // RULE9
        end
        else
        begin
            m = ipm_pkg::IPM_PD; // RULE23
            per = 16'h0000;
        end
        return {m, per};
    endfunction

    ipm_pkg::ipm_state_t state_q, state_d;
    logic [23:0] boot_cnt_q, boot_cnt_d;
    logic [7:0] trim_q, trim_d;
    logic [1:0] am_q, am_d, gm_q, gm_d;
    logic [15:0] aper_q, aper_d, gper_q, gper_d;
    logic [15:0] acnt_q, acnt_d, gcnt_q, gcnt_d;
    logic [7:0] div_q, div_d;
    logic adr_q, adr_d, gdr_q, gdr_d;
    logic aaa_q, aaa_d, hub_q, hub_d, upd_q, upd_d;
    logic [15:0] lpf_q, lpf_d;
    logic [1:0] host_sync_q;
    logic tick;
    logic [17:0] adec, gdec;
    logic a_end, g_end;

    assign adec = decode(accel_rate_code, accel_hp_disable, 1'b1); // RULE6
    assign gdec = decode(gyro_rate_code, gyro_hp_disable, 1'b0); // RULE11
    assign tick = (div_q == 8'(BASE_DIV - 1));
    assign a_end = tick && (acnt_q == 16'h0000);
    assign g_end = tick && (gcnt_q == 16'h0000);

    // boot sequencer and trim load
    always_comb
    begin
        state_d = state_q;
        boot_cnt_d = boot_cnt_q;
        trim_d = trim_q;
        case (state_q)
            ipm_pkg::IPM_ST_BOOT:
            begin
                boot_cnt_d = boot_cnt_q + 24'h000001;
                if (trim_q != 8'(TRIM_WORDS))
                begin
                    trim_d = trim_q + 8'h01; // RULE1
                end
                if (boot_cnt_q >= 24'(BOOT_CYC - 1))
                begin
                    state_d = ipm_pkg::IPM_ST_RUN; // RULE1
                end
            end
            ipm_pkg::IPM_ST_RUN: state_d = ipm_pkg::IPM_ST_RUN;
            default: state_d = ipm_pkg::IPM_ST_BOOT;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ipm_pkg::IPM_ST_BOOT;
            boot_cnt_q <= 24'h000000;
            trim_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            boot_cnt_q <= boot_cnt_d;
            trim_q <= trim_d;
        end
    end

    // trim storage written during boot
    ipm_trim_mem #(
        .DEPTH(TRIM_WORDS),
        .WIDTH(8)
    ) u_trim (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(state_q == ipm_pkg::IPM_ST_BOOT && trim_q != 8'(TRIM_WORDS)),
        .addr(trim_q[$clog2(TRIM_WORDS)-1:0]),
        .wr_data(trim_q ^ 8'hA5),
        .rd_data()
    );

    // host activity pin, two-stage synchroniser
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_sync_q <= 2'b00;
        end
        else
        begin
            host_sync_q <= {host_sync_q[0], host_if_req};
        end
    end

    // mode, rate timers and data-ready generation
    always_comb
    begin
        div_d = tick ? 8'h00 : div_q + 8'h01;
        am_d = am_q;
        gm_d = gm_q;
        aper_d = aper_q;
        gper_d = gper_q;
        acnt_d = acnt_q;
        gcnt_d = gcnt_q;
        adr_d = 1'b0;
        gdr_d = 1'b0;
        if (state_q != ipm_pkg::IPM_ST_RUN)
        begin
            am_d = ipm_pkg::IPM_PD; // RULE2
            gm_d = ipm_pkg::IPM_PD; // RULE2
        end
        else
        begin
            // gyro: new setting only at period end or from idle
            if (gm_q == ipm_pkg::IPM_PD || gm_q == ipm_pkg::IPM_SLEEP || g_end)
            begin
                gm_d = gdec[17:16]; // RULE22 RULE4
                gper_d = gdec[15:0];
                if (gdec[17:16] != ipm_pkg::IPM_PD && gyro_sleep_req)
                begin
                    gm_d = ipm_pkg::IPM_SLEEP; // RULE12 RULE13
                end
                gcnt_d = gdec[15:0] - 16'h0001;
                gdr_d = g_end && gm_q != ipm_pkg::IPM_PD && gm_q != ipm_pkg::IPM_SLEEP; // RULE16 RULE17
            end
            else if (tick)
            begin
                gcnt_d = gcnt_q - 16'h0001;
            end
            // accel: period end, or leave idle only on a gyro period end while gyro runs
            if (am_q == ipm_pkg::IPM_PD ? (g_end || gm_q == ipm_pkg::IPM_PD
                || gm_q == ipm_pkg::IPM_SLEEP) : a_end) // RULE5
            begin
                am_d = adec[17:16]; // RULE22 RULE3 RULE4
                aper_d = adec[15:0];
                acnt_d = adec[15:0] - 16'h0001;
                adr_d = a_end && am_q != ipm_pkg::IPM_PD; // RULE16 RULE17
            end
            else if (tick)
            begin
                acnt_d = acnt_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q <= 8'h00;
            am_q <= ipm_pkg::IPM_PD;
            gm_q <= ipm_pkg::IPM_PD;
            aper_q <= 16'h0000;
            gper_q <= 16'h0000;
            acnt_q <= 16'h0000;
            gcnt_q <= 16'h0000;
            adr_q <= 1'b0;
            gdr_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            am_q <= am_d;
            gm_q <= gm_d;
            aper_q <= aper_d;
            gper_q <= gper_d;
            acnt_q <= acnt_d;
            gcnt_q <= gcnt_d;
            adr_q <= adr_d;
            gdr_q <= gdr_d;
        end
    end

    // filter, connection mode and data update controls
    always_comb
    begin
        aaa_d = (am_q == ipm_pkg::IPM_HP); // RULE20
        lpf_d = 16'h0000;
        if (am_q == ipm_pkg::IPM_HP)
        begin
            lpf_d = 16'((32'h00001A0B / {16'h0000, aper_q}) >> 1); // RULE21
        end
        else if (am_q == ipm_pkg::IPM_LP)
        begin
            lpf_d = `IPM_LP_CUTOFF_HZ; // RULE21
        end
        hub_d = (state_q == ipm_pkg::IPM_ST_RUN) && hub_mode_req; // RULE18 RULE19
        upd_d = (am_q != ipm_pkg::IPM_PD) || (gm_q == ipm_pkg::IPM_LP)
                || (gm_q == ipm_pkg::IPM_HP); // RULE15
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aaa_q <= 1'b0;
            lpf_q <= 16'h0000;
            hub_q <= 1'b0;
            upd_q <= 1'b0;
        end
        else
        begin
            aaa_q <= aaa_d;
            lpf_q <= lpf_d;
            hub_q <= hub_d;
            upd_q <= upd_d;
        end
    end

    // registered outputs
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boot_done <= 1'b0;
            accel_mode <= 2'b00;
            gyro_mode <= 2'b00;
            accel_drdy <= 1'b0;
            gyro_drdy <= 1'b0;
            accel_chain_on <= 1'b0;
            gyro_chain_on <= 1'b0;
            gyro_drive_on <= 1'b0;
            accel_aa_en <= 1'b0;
            first_digital_lowpass <= 16'h0000;
            host_if_en <= 1'b0;
            hub_master_en <= 1'b0;
            data_update_en <= 1'b0;
            host_if_seen <= 1'b0;
        end
        else
        begin
            boot_done <= (state_q == ipm_pkg::IPM_ST_RUN);
            accel_mode <= am_q;
            gyro_mode <= gm_q;
            accel_drdy <= adr_q;
            gyro_drdy <= gdr_q;
            accel_chain_on <= (am_q == ipm_pkg::IPM_HP) || (am_q == ipm_pkg::IPM_LP && a_end); // RULE16 RULE17
            gyro_chain_on <= (gm_q == ipm_pkg::IPM_HP) || (gm_q == ipm_pkg::IPM_LP && g_end); // RULE16 RULE17
            gyro_drive_on <= (gm_q != ipm_pkg::IPM_PD); // RULE12
            accel_aa_en <= aaa_q;
            first_digital_lowpass <= lpf_q;
            host_if_en <= (state_q == ipm_pkg::IPM_ST_RUN); // RULE14
            hub_master_en <= hub_q;
            data_update_en <= upd_q;
            host_if_seen <= host_sync_q[1];
        end
    end

endmodule // ipm_power_ctrl

/* File: include/ipm_map.svh */
`ifndef IPM_MAP_SVH
`define IPM_MAP_SVH

// boot time and derived cycle count at 20 MHz
`define IPM_CLK_HZ 20000000
`define IPM_BOOT_MS 10
`define IPM_BOOT_CYC ((`IPM_CLK_HZ / 1000) * `IPM_BOOT_MS)

// rate code values
`define IPM_CODE_PD 4'h0
`define IPM_CODE_LP_LO 4'h1
`define IPM_CODE_LP_HI 4'h5
`define IPM_CODE_HP_LO 4'h6
`define IPM_CODE_HP_HI 4'hA
`define IPM_CODE_XL_1P6 4'hB

// low-power lowpass cutoff in Hz
`define IPM_LP_CUTOFF_HZ 16'h02BC

// rate table width: period in base ticks of the highest rate
`define IPM_PER_W 16

`endif

/* File: include/ipm_pkg.sv */
package ipm_pkg;

    // power mode of one sensor
    typedef enum logic [1:0] {
        IPM_PD = 2'b00,
        IPM_LP = 2'b01,
        IPM_HP = 2'b10,
        IPM_SLEEP = 2'b11
    } ipm_mode_t;

    // boot sequencer states
    typedef enum logic [1:0] {
        IPM_ST_BOOT = 2'b00,
        IPM_ST_TRIM = 2'b01,
        IPM_ST_RUN = 2'b10
    } ipm_state_t;

endpackage

/* File: src/ipm_trim_mem.sv */
`timescale 1ns/10ps
`include "ipm_map.svh"

module ipm_trim_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8
) (
    input wire logic clock, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic wr_en, // write strobe
    input wire logic [$clog2(DEPTH)-1:0] addr, // word address
    input wire logic [WIDTH-1:0] wr_data, // write data
    output logic [WIDTH-1:0] rd_data // registered read data
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rd_data_q;

    // storage, no reset on the array
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[addr] <= wr_data;
        end
    end

    // registered read port
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q <= '0;
        end
        else
        begin
            rd_data_q <= mem[addr];
        end
    end

    assign rd_data = rd_data_q;

endmodule // ipm_trim_mem

/* File: verif/ipm_power_ctrl_sva.sv */
`timescale 1ns/10ps
module ipm_power_ctrl_sva #(
    parameter int BOOT_CYC = 50
) (
    input wire logic clock, // clk
    input wire logic rst_n, // reset
    input wire logic hub_mode_req, // hub req
    input wire logic host_if_req, // link pin
    input wire logic boot_done, // booted
    input wire logic [1:0] accel_mode, // accel mode
    input wire logic [1:0] gyro_mode, // gyro mode
    input wire logic accel_drdy, // accel ready
    input wire logic gyro_drdy, // gyro ready
    input wire logic gyro_drive_on, // drive
    input wire logic accel_aa_en, // aa filter
    input wire logic [15:0] first_digital_lowpass, // cutoff
    input wire logic hub_master_en, // hub master
    input wire logic data_update_en, // update
    input wire logic host_if_seen // link seen
);
    logic [31:0] cyc_d;
    logic [31:0] cyc_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // cycles from reset release until boot ends
    always_comb cyc_d = boot_done ? cyc_q : cyc_q + 32'h1;
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            cyc_q <= 32'h0;
        else
            cyc_q <= cyc_d;
    // boot timing and state
    a_boot_len: assert property ($rose(boot_done) |->
        cyc_q >= BOOT_CYC - 1 && cyc_q <= BOOT_CYC + 2) else $error("boot length off");
    a_boot_hold: assert property (boot_done |=> boot_done) else $error("boot lost");
    a_boot_pd: assert property (!boot_done |->
        accel_mode == ipm_pkg::IPM_PD && gyro_mode == ipm_pkg::IPM_PD) else $error("not pd");
    // filter and drive follow mode
    a_aa_hp: assert property (accel_aa_en |->
        accel_mode == ipm_pkg::IPM_HP || $past(accel_mode) == ipm_pkg::IPM_HP)
        else $error("aa outside hp");
    a_lp_cut: assert property (accel_mode == ipm_pkg::IPM_LP &&
        $past(accel_mode) == ipm_pkg::IPM_LP |-> first_digital_lowpass == 16'h02BC)
        else $error("lp cutoff");
    a_sleep_drive: assert property (gyro_mode == ipm_pkg::IPM_SLEEP &&
        $past(gyro_mode) == ipm_pkg::IPM_SLEEP |-> gyro_drive_on) else $error("drive off");
    a_drdy_gap: assert property (accel_drdy |=> !accel_drdy [*2])
        else $error("drdy too close");
    a_hub_follow: assert property (boot_done && $past(boot_done) |->
        hub_master_en == $past(hub_mode_req, 2)) else $error("hub master");
    a_link_sync: assert property (boot_done && $past(boot_done, 3) |->
        host_if_seen == $past(host_if_req, 3)) else $error("link sync");
    a_pd_frozen: assert property (accel_mode == 2'h0 && gyro_mode == 2'h0 &&
        $past(accel_mode | gyro_mode) == 2'h0 |-> !data_update_en) else $error("update in pd");
    // main scenarios
    c_lp: cover property (accel_mode == ipm_pkg::IPM_LP);
    c_sleep: cover property (gyro_mode == ipm_pkg::IPM_SLEEP);
    c_sync: cover property (accel_drdy && gyro_drdy);
endmodule // ipm_power_ctrl_sva

bind ipm_power_ctrl ipm_power_ctrl_sva #(.BOOT_CYC(BOOT_CYC)) ipm_power_ctrl_sva_inst (
    .clock(clock), .rst_n(rst_n), .hub_mode_req(hub_mode_req), .host_if_req(host_if_req),
    .boot_done(boot_done), .accel_mode(accel_mode), .gyro_mode(gyro_mode),
    .accel_drdy(accel_drdy), .gyro_drdy(gyro_drdy), .gyro_drive_on(gyro_drive_on),
    .accel_aa_en(accel_aa_en), .first_digital_lowpass(first_digital_lowpass),
    .hub_master_en(hub_master_en), .data_update_en(data_update_en),
    .host_if_seen(host_if_seen));

/* File: verif/ipm_host_model.sv */
`timescale 1ns/10ps
module ipm_host_model (
    input wire logic frame_en, // host transfer running
    output logic host_if_req // serial clock at the pin
);
    // 400 ns link clock, idle low between frames
    initial
    begin
        host_if_req = 1'b0;
        #7;
        forever
        begin
            #200;
            host_if_req = frame_en ? ~host_if_req : 1'b0;
        end
    end
endmodule // ipm_host_model

/* File: verif/inertial_power_mode_control_test.sv */
`timescale 1ns/10ps
module inertial_power_mode_control_test;
    localparam int BOOT = 50;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] xl_code = 4'hA;
    logic xl_dis = 1'b0;
    logic [3:0] g_code = 4'hA;
    logic g_dis = 1'b0;
    logic g_sleep = 1'b0;
    logic hub_req = 1'b0;
    logic frame_en = 1'b0;
    logic host_req;
    logic boot_done, accel_drdy, gyro_drdy, xl_chain, g_chain, g_drive, aa_en;
    logic if_en, hub_en, upd_en, if_seen;
    logic [1:0] accel_mode;
    logic [1:0] gyro_mode;
    logic [15:0] lpf;
    logic [31:0] seed = 32'h0000379D;
    int n_mismatch = 0;
    int cmp_count = 0;
    int na, ng, nb, nc, nt;

    always #25 clock = ~clock;

    ipm_power_ctrl #(.BOOT_CYC(BOOT)) ipm_power_ctrl_inst (
        .clock(clock), .rst_n(rst_n), .accel_rate_code(xl_code), .accel_hp_disable(xl_dis),
        .gyro_rate_code(g_code), .gyro_hp_disable(g_dis), .gyro_sleep_req(g_sleep),
        .hub_mode_req(hub_req), .host_if_req(host_req), .boot_done(boot_done),
        .accel_mode(accel_mode), .gyro_mode(gyro_mode), .accel_drdy(accel_drdy),
        .gyro_drdy(gyro_drdy), .accel_chain_on(xl_chain), .gyro_chain_on(g_chain),
        .gyro_drive_on(g_drive), .accel_aa_en(aa_en), .first_digital_lowpass(lpf),
        .host_if_en(if_en), .hub_master_en(hub_en), .data_update_en(upd_en),
        .host_if_seen(if_seen));

    ipm_host_model ipm_host_model_inst (.frame_en(frame_en), .host_if_req(host_req));

    // xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // expected accel mode from code and disable bit
    function automatic logic [1:0] exp_xl(input logic [3:0] c, input logic d);
        if (c == 4'h0 || c > 4'hB)
            return ipm_pkg::IPM_PD;
        if (c >= 4'h6 && c <= 4'hA)
            return ipm_pkg::IPM_HP;
        return d ? ipm_pkg::IPM_LP : ipm_pkg::IPM_HP;
    endfunction

    // expected gyro mode, sleep only when not powered down
    function automatic logic [1:0] exp_g(input logic [3:0] c, input logic d, input logic s);
        if (c == 4'h0 || c > 4'hA)
            return ipm_pkg::IPM_PD;
        return s ? ipm_pkg::IPM_SLEEP : exp_xl(c, d);
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_num(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi)
        begin
            n_mismatch++;
            $display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // wait for both modes, bounded by the slowest period
    task automatic settle(input logic [1:0] ea, input logic [1:0] eg);
        int k;
        k = 0;
        while ((accel_mode !== ea || gyro_mode !== eg) && k < 13000)
        begin
            cyc(1);
            k++;
        end
        cyc(1);
    endtask

    task automatic wait_boot;
        int k;
        k = 0;
        while (boot_done !== 1'b1 && k < BOOT + 10)
        begin
            cyc(1);
            k++;
        end
    endtask

    // count pulses and link activity over n cycles
    task automatic count(input int n);
        logic p;
        {na, ng, nb, nc, nt} = '0;
        p = if_seen;
        repeat (n)
        begin
            cyc(1);
            na += int'(accel_drdy);
            ng += int'(gyro_drdy);
            nb += int'(accel_drdy & gyro_drdy);
            nc += int'(xl_chain);
            nt += int'(if_seen !== p);
            p = if_seen;
        end
    endtask

    task automatic stop_test;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // main sequence
    initial
    begin
        logic [1:0] ea;
        logic [1:0] eg;
        cyc(2);
        rst_n = 1'b1;
        cyc(10);
        cmp_val(boot_done, 1'b0);
        cmp_val(accel_mode | gyro_mode, ipm_pkg::IPM_PD);
        wait_boot();
        cmp_val(boot_done, 1'b1);
        $display("test boot done");
        for (int i = 0; i < 32; i++)
        begin
            seed = xs(seed);
            xl_code = i[4:1];
            xl_dis = i[0];
            g_code = i[4:1];
            g_dis = ~i[0];
            g_sleep = seed[0] | (i < 2);
            hub_req = seed[1];
            ea = exp_xl(xl_code, xl_dis);
            eg = exp_g(g_code, g_dis, g_sleep);
            cyc(3);
            settle(ea, eg);
            cmp_val(accel_mode, ea);
            cmp_val(gyro_mode, eg);
            cmp_val(aa_en, ea == ipm_pkg::IPM_HP);
            cmp_val(g_drive, eg != ipm_pkg::IPM_PD);
            cmp_val(hub_en, hub_req);
            if (ea == ipm_pkg::IPM_LP)
                cmp_val(lpf, 16'h02BC);
        end
        $display("test table done");
        g_code = 4'h9;
        g_sleep = 1'b0;
        cyc(7);
        xl_code = 4'h8;
        settle(ipm_pkg::IPM_HP, ipm_pkg::IPM_HP);
        cyc(20);
        count(36);
        cmp_num(ng, 6, 6);
        cmp_num(na, 3, 3);
        cmp_num(nb, na, na);
        cmp_num(nc, 36, 36);
        cmp_val(g_chain, 1'b1);
        cmp_val(lpf, 16'h0341);
        $display("test sync done");
        xl_code = 4'h5;
        xl_dis = 1'b1;
        g_code = 4'h0;
        settle(ipm_pkg::IPM_LP, ipm_pkg::IPM_PD);
        count(400);
        cmp_num(na, 4, 5);
        cmp_num(nc, 4, 5);
        $display("test low power done");
        xl_code = 4'hB;
        settle(ipm_pkg::IPM_LP, ipm_pkg::IPM_PD);
        cyc(2); // let a pulse of the old period pass
        na = 0;
        while (accel_drdy !== 1'b1 && na < 13000)
        begin
            cyc(1);
            na++;
        end
        xl_code = 4'hA;
        cyc(100);
        cmp_val(accel_mode, ipm_pkg::IPM_LP);
        settle(ipm_pkg::IPM_HP, ipm_pkg::IPM_PD);
        cmp_val(accel_mode, ipm_pkg::IPM_HP);
        $display("test period change done");
        xl_code = 4'h0;
        settle(ipm_pkg::IPM_PD, ipm_pkg::IPM_PD);
        frame_en = 1'b1;
        count(80);
        frame_en = 1'b0;
        cmp_num(nt, 4, 80);
        cmp_val(if_en, 1'b1);
        cmp_val(upd_en, 1'b0);
        $display("test power down link done");
        xl_code = 4'h6;
        rst_n = 1'b0;
        cyc(1);
        cmp_val({boot_done, accel_mode}, 3'h0);
        rst_n = 1'b1;
        wait_boot();
        cmp_val(boot_done, 1'b1);
        $display("test second reset done");
        stop_test();
    end

    // hang guard
    initial
    begin
        cyc(90000);
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end
endmodule // inertial_power_mode_control_test
